// File: verilog/ldocs_channel_ctrl.sv
// Control logic of one auxiliary linear regulator channel: registers over APB,
// start-up step handling, channel enable and interrupt on fault, soft-start done or power-good loss.
// Assumes step starts and regulator flags are synchronous to CLOCK.
`timescale 1ns/1ps
module ldocs_channel_ctrl
#(
    parameter int TICK_CYC = ldocs_pkg::DELAY_TICK_CYC
)
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ldocs_pkg::APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [5:0] OUTPUT_VOLTAGE_CODE_STRAP,
    input wire logic HP_MODE,
    input wire logic OTHER_MODE_EN,
    input wire logic STEP_START,
    input wire logic [1:0] STEP_INDEX,
    input wire logic SEQ_ABORT,
    input wire logic SOFT_START_DONE_FLAG,
    input wire logic POWER_GOOD_FLAG,
    input wire logic FAULT_FLAG,
    output logic CH_ON,
    output logic SOFT_START_GO,
    output logic STEP_READY,
    output logic [5:0] OUTPUT_VOLTAGE_CODE,
    output logic [1:0] SOFT_START_RATE,
    output logic [1:0] VOLTAGE_RAMP_RATE,
    output logic OUTPUT_BLEED_CTRL,
    output logic INTERRUPT_OUT_N
);
    import ldocs_pkg::*;

    function automatic logic [7:0] reg_index(input logic [APB_AW-1:0] addr);
        reg_index = addr[9:2];
    endfunction

    function automatic logic is_mapped(input logic [APB_AW-1:0] addr);
        logic [7:0] idx;
        idx = reg_index(addr);
        is_mapped = (addr[1:0] == 2'b00) && (idx >= IDX_HP_SET) && (idx <= IDX_CH_STAT);
    endfunction

    logic [7:0] hp_r, hp_nxt;
    logic [7:0] seq_r, seq_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [IRQ_W-1:0] stat_r, stat_nxt;
    logic [IRQ_W-1:0] mask_r, mask_nxt;
    logic strap_done_r, strap_done_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic fault_d_r, ssd_d_r, pgood_d_r;
    ldocs_state_t state_r, state_nxt;
    logic go_r, go_nxt;
    logic ch_on_r, ch_on_nxt;
    logic timer_load;
    logic timer_exp;
    logic wr_en;
    logic [7:0] wr_idx;
    logic participate;
    logic [IRQ_W-1:0] irq_set;

    // A write that answers with an error leaves every register as it was.
    assign wr_en = PSEL && PENABLE && PWRITE && is_mapped(PADDR);
    assign wr_idx = reg_index(PADDR);
    assign participate = seq_r[SEQ_PART_BIT];

    // Register file.
    always_comb
    begin
        hp_nxt = hp_r;
        seq_nxt = seq_r;
        cfg_nxt = cfg_r;
        mask_nxt = mask_r;
        strap_done_nxt = 1'b1;
        prdata_nxt = prdata_r;
        if (!strap_done_r)
        begin
            hp_nxt[5:0] = OUTPUT_VOLTAGE_CODE_STRAP;
        end
        if (wr_en)
        begin
            case (wr_idx)
                IDX_HP_SET: hp_nxt = PWDATA[7:0] & 8'hBF;
                IDX_SEQ: seq_nxt = PWDATA[7:0];
                IDX_CFG: cfg_nxt = (PWDATA[7:0] & CFG_WMASK) | 8'h10;
                IDX_IRQ_MASK: mask_nxt = PWDATA[IRQ_W-1:0];
                default: mask_nxt = mask_nxt;
            endcase
        end
        if (PSEL && !PENABLE)
        begin
            case (reg_index(PADDR))
                IDX_HP_SET: prdata_nxt = {24'h000000, hp_r};
                IDX_SEQ: prdata_nxt = {24'h000000, seq_r};
                IDX_CFG: prdata_nxt = {24'h000000, cfg_r};
                IDX_IRQ_STAT: prdata_nxt = {29'h00000000, stat_r};
                IDX_IRQ_MASK: prdata_nxt = {29'h00000000, mask_r};
                IDX_CH_STAT: prdata_nxt = {24'h000000, ch_on_r, STEP_READY, FAULT_FLAG,
                    POWER_GOOD_FLAG, SOFT_START_DONE_FLAG, 1'b0, state_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            hp_r <= {HP_EN_RST, 7'h00};
            seq_r <= SEQ_RST;
            cfg_r <= CFG_RST;
            mask_r <= IRQ_MASK_RST;
            strap_done_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            hp_r <= hp_nxt;
            seq_r <= seq_nxt;
            cfg_r <= cfg_nxt;
            mask_r <= mask_nxt;
            strap_done_r <= strap_done_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // Interrupt status: hardware set wins over a write-one clear.
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_FAULT] = FAULT_FLAG && !fault_d_r;
        irq_set[IRQ_SS_DONE] = SOFT_START_DONE_FLAG && !ssd_d_r && participate;
        irq_set[IRQ_PGOOD_LOST] = !POWER_GOOD_FLAG && pgood_d_r && ch_on_r;
        stat_nxt = stat_r;
        if (wr_en && (wr_idx == IDX_IRQ_STAT))
        begin
            stat_nxt = stat_r & ~PWDATA[IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | irq_set;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            stat_r <= '0;
            fault_d_r <= 1'b0;
            ssd_d_r <= 1'b0;
            pgood_d_r <= 1'b0;
        end
        else
        begin
            stat_r <= stat_nxt;
            fault_d_r <= FAULT_FLAG;
            ssd_d_r <= SOFT_START_DONE_FLAG;
            pgood_d_r <= POWER_GOOD_FLAG;
        end
    end

    // Start-up step handling and channel enable.
    always_comb
    begin
        state_nxt = state_r;
        go_nxt = 1'b0;
        timer_load = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (STEP_START && (STEP_INDEX == seq_r[SEQ_SLOT_LSB +: 2]) && participate)
                begin
                    timer_load = 1'b1;
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (timer_exp)
                begin
                    go_nxt = 1'b1;
                    state_nxt = ST_RAMP;
                end
            end
            ST_RAMP:
            begin
                if (SOFT_START_DONE_FLAG)
                begin
                    state_nxt = ST_ON;
                end
            end
            ST_ON: state_nxt = ST_ON;
            default: state_nxt = ST_IDLE;
        endcase
        if (SEQ_ABORT)
        begin
            state_nxt = ST_IDLE;
            go_nxt = 1'b0;
        end
        if (cfg_r[CFG_REGISTER_OVERRIDE_CTRL_BIT])
        begin
            ch_on_nxt = cfg_r[CFG_REN_BIT];
        end
        else if (HP_MODE)
        begin
            // The sequencer owns the first turn-on; it stays on while the setting is set and no abort returns the state to ST_IDLE.
            ch_on_nxt = hp_r[HP_EN_BIT] && (state_r == ST_RAMP || state_r == ST_ON);
        end
        else
        begin
            ch_on_nxt = OTHER_MODE_EN;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_r <= ST_IDLE;
            go_r <= 1'b0;
            ch_on_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            go_r <= go_nxt;
            ch_on_r <= ch_on_nxt;
        end
    end

    ldocs_delay_timer
    #(
        .TICK_CYC(TICK_CYC),
        .DW(3)
    )
    u_delay
    (
        .CLOCK(CLOCK),
        .NRST(NRST),
        .LOAD(timer_load),
        .ABORT(SEQ_ABORT),
        .TICKS(seq_r[SEQ_DLY_LSB +: 3]),
        .EXPIRED(timer_exp)
    );

    assign STEP_READY = !participate || (SOFT_START_DONE_FLAG && POWER_GOOD_FLAG);
    assign CH_ON = ch_on_r;
    assign SOFT_START_GO = go_r;
    assign OUTPUT_VOLTAGE_CODE = hp_r[5:0];
    assign SOFT_START_RATE = seq_r[SEQ_RATE_LSB +: 2];
    assign VOLTAGE_RAMP_RATE = cfg_r[CFG_RAMP_LSB +: 2];
    assign OUTPUT_BLEED_CTRL = cfg_r[CFG_BLEED_BIT];
    // Fault is also held off by the configuration fault mask.
    assign INTERRUPT_OUT_N = !(|(stat_r & ~mask_r & {2'b11, !cfg_r[CFG_MASK_BIT]}));
    assign PRDATA = prdata_r;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !is_mapped(PADDR);
endmodule // ldocs_channel_ctrl

// File: verilog/ldocs_pkg.sv
// Package for the regulator channel sequencing control block.
// Assumes a 40 MHz CLOCK and an APB master with 32-bit data.
package ldocs_pkg;
    localparam int CLOCK_HZ = 40_000_000;
    localparam int APB_AW = 10;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_HP_SET = 8'h53;
    localparam logic [7:0] IDX_SEQ = 8'h54;
    localparam logic [7:0] IDX_CFG = 8'h55;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h56;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h57;
    localparam logic [7:0] IDX_CH_STAT = 8'h58;
    // High-performance setting fields.
    localparam int HP_EN_BIT = 7;
    localparam int RSV_BIT = 6;
    localparam logic HP_EN_RST = 1'b1;
    // Sequencing fields.
    localparam int SEQ_RATE_LSB = 6;
    localparam int SEQ_SLOT_LSB = 4;
    localparam int SEQ_PART_BIT = 3;
    localparam int SEQ_DLY_LSB = 0;
    localparam logic [7:0] SEQ_RST = 8'h09;
    // Configuration fields.
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_BLEED_BIT = 5;
    localparam int CFG_RSV1_BIT = 4;
    localparam int CFG_RAMP_LSB = 2;
    localparam int CFG_REN_BIT = 1;
    localparam int CFG_REGISTER_OVERRIDE_CTRL_BIT = 0;
    localparam logic [7:0] CFG_RST = 8'hB0;
    localparam logic [7:0] CFG_WMASK = 8'hAF;
    // Interrupt status bits.
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_SS_DONE = 1;
    localparam int IRQ_PGOOD_LOST = 2;
    localparam int IRQ_W = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    // Turn-on delay tick.
    localparam int DELAY_TICK_NS = 1000;
    localparam int DELAY_TICK_CYC = (DELAY_TICK_NS * (CLOCK_HZ / 1_000_000)) / 1000;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RAMP = 2'b11,
        ST_ON = 2'b10
    } ldocs_state_t;
endpackage

// File: verilog/ldocs_delay_timer.sv
// Turn-on delay counter: loaded with a tick count, pulses when it runs out.
// Assumes LOAD is a one-cycle pulse from the sequencer.
`timescale 1ns/1ps
module ldocs_delay_timer
#(
    parameter int TICK_CYC = 40,
    parameter int DW = 3
)
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic LOAD,
    input wire logic ABORT,
    input wire logic [DW-1:0] TICKS,
    output logic EXPIRED
);
    logic [15:0] pre_r, pre_nxt;
    logic [DW-1:0] cnt_r, cnt_nxt;
    logic run_r, run_nxt;
    logic exp_r, exp_nxt;

    always_comb
    begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        exp_nxt = 1'b0;
        if (ABORT)
        begin
            run_nxt = 1'b0;
        end
        else if (LOAD)
        begin
            pre_nxt = 16'(TICK_CYC - 1);
            cnt_nxt = TICKS;
            run_nxt = 1'b1;
        end
        else if (run_r)
        begin
            // A zero count expires on the first pass.
            if (cnt_r == '0)
            begin
                run_nxt = 1'b0;
                exp_nxt = 1'b1;
            end
            else if (pre_r == 16'h0000)
            begin
                pre_nxt = 16'(TICK_CYC - 1);
                cnt_nxt = cnt_r - 1'b1;
            end
            else
            begin
                pre_nxt = pre_r - 16'h0001;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            pre_r <= 16'h0000;
            cnt_r <= '0;
            run_r <= 1'b0;
            exp_r <= 1'b0;
        end
        else
        begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign EXPIRED = exp_r;
endmodule // ldocs_delay_timer

// File: test/ldocs_sva.sv
// Port checker for the regulator channel control block.
// Assumes the testbench binds it to ldocs_channel_ctrl.
`timescale 1ns/1ps
module ldocs_sva
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic STEP_START,
    input wire logic SEQ_ABORT,
    input wire logic FAULT_FLAG,
    input wire logic SOFT_START_DONE_FLAG,
    input wire logic POWER_GOOD_FLAG,
    input wire logic SOFT_START_GO,
    input wire logic INTERRUPT_OUT_N
);
    logic armed_r;
    logic armed_nxt;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);
    // A step start arms the channel until the sequencer is aborted.
    always_comb armed_nxt = (armed_r || STEP_START) && !SEQ_ABORT;
    always_ff @(posedge CLOCK or negedge NRST)
        if (!NRST)
            armed_r <= 1'b0;
        else
            armed_r <= armed_nxt;
    chk_ready_access: assert property (PSEL && PENABLE |-> PREADY)
        else $error("pready low in access");
    chk_slverr_access: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("pslverr outside access");
    chk_rdata_upper: assert property (PRDATA[31:8] == 24'h000000)
        else $error("upper read data not zero");
    chk_rdata_hold: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
        else $error("read data moved outside setup");
    chk_go_pulse: assert property (SOFT_START_GO |=> !SOFT_START_GO)
        else $error("soft start go longer than one cycle");
    chk_go_needs_step: assert property (SOFT_START_GO |-> armed_r)
        else $error("soft start go without step start");
    chk_abort_no_go: assert property (SEQ_ABORT [*2] |=> !SOFT_START_GO)
        else $error("soft start go after abort");
    chk_irq_fall_cause: assert property ($fell(INTERRUPT_OUT_N) |->
        $past(FAULT_FLAG || SOFT_START_DONE_FLAG || !POWER_GOOD_FLAG || PWRITE && PENABLE))
        else $error("interrupt asserted without cause");
    chk_irq_rise_write: assert property ($rose(INTERRUPT_OUT_N) |->
        $past(PSEL && PENABLE && PWRITE)) else $error("interrupt released without write");
    cov_go: cover property (SOFT_START_GO);
    cov_irq: cover property ($fell(INTERRUPT_OUT_N));
    cov_slverr: cover property (PSLVERR);
endmodule // ldocs_sva

// File: test/testbench.sv
// Self-checking bench for the regulator channel control block.
// Assumes ldocs_pkg and the design files are compiled first.
`timescale 1ns/1ps
module testbench;
    import ldocs_pkg::*;
    logic CLOCK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, HP_MODE = 1;
    logic OTHER_MODE_EN = 0, STEP_START = 0, SEQ_ABORT = 0, SOFT_START_DONE_FLAG = 0;
    logic POWER_GOOD_FLAG = 0, FAULT_FLAG = 0, PREADY, PSLVERR, CH_ON, SOFT_START_GO, err;
    logic STEP_READY, OUTPUT_BLEED_CTRL, INTERRUPT_OUT_N;
    logic [9:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, q;
    logic [5:0] OUTPUT_VOLTAGE_CODE_STRAP = 0, OUTPUT_VOLTAGE_CODE;
    logic [1:0] STEP_INDEX = 0, SOFT_START_RATE, VOLTAGE_RAMP_RATE;
    int num_errors = 0, compares = 0, n, d, s;
    int mdl[int];
    ldocs_channel_ctrl #(.TICK_CYC(2)) u_dut (.CLOCK, .NRST, .PSEL, .PENABLE, .PWRITE,
        .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .OUTPUT_VOLTAGE_CODE_STRAP, .HP_MODE, .OTHER_MODE_EN,
        .STEP_START, .STEP_INDEX, .SEQ_ABORT, .SOFT_START_DONE_FLAG, .POWER_GOOD_FLAG,
        .FAULT_FLAG, .CH_ON, .SOFT_START_GO, .STEP_READY, .OUTPUT_VOLTAGE_CODE,
        .SOFT_START_RATE, .VOLTAGE_RAMP_RATE, .OUTPUT_BLEED_CTRL, .INTERRUPT_OUT_N);
    initial forever #12.5 CLOCK = ~CLOCK;
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(int c);
        repeat (c) @(posedge CLOCK);
    endtask
    task automatic apb(logic w, logic [7:0] ix, logic [31:0] wd);
        int k;
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= {ix, 2'b00};
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1;
        k = 0;
        do
        begin
            @(posedge CLOCK);
            k++;
        end
        while (PREADY !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            chk("pready", 1, 0);
            give_verdict();
        end
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        // One idle cycle, so that the next request does not drive PSEL twice at once.
        @(posedge CLOCK);
        if (w)
            case (ix)
                IDX_HP_SET: mdl[ix] = wd & 8'hBF;
                IDX_SEQ: mdl[ix] = wd & 8'hFF;
                IDX_CFG: mdl[ix] = wd & 8'hAF | 8'h10;
                IDX_IRQ_MASK: mdl[ix] = wd & 8'h07;
                IDX_IRQ_STAT: mdl[ix] = mdl[ix] & ~wd;
                default: ;
            endcase
    endtask
    task automatic rd(logic [7:0] ix);
        apb(0, ix, 0);
        chk("register", mdl.exists(ix) ? mdl[ix] : 0, q);
    endtask
    task automatic step(logic [1:0] ix);
        STEP_INDEX <= ix;
        STEP_START <= 1;
        @(posedge CLOCK);
        STEP_START <= 0;
    endtask
    task automatic abort();
        SEQ_ABORT <= 1;
        tick(2);
        SEQ_ABORT <= 0;
        tick(1);
    endtask
    task automatic go_wait(int lim);
        n = 0;
        while (SOFT_START_GO !== 1'b1 && n < lim)
        begin
            @(posedge CLOCK);
            n++;
        end
    endtask
    task automatic onchk(logic [31:0] w, logic e);
        apb(1, IDX_CFG, w);
        tick(2);
        chk("channel on", e, CH_ON);
    endtask
    initial
    begin
        void'($urandom(32'hC1FFC664));
        OUTPUT_VOLTAGE_CODE_STRAP <= 6'($urandom);
        tick(4);
        NRST <= 1;
        tick(2);
        mdl[IDX_HP_SET] = 8'h80 | OUTPUT_VOLTAGE_CODE_STRAP;
        mdl[IDX_SEQ] = 8'h09;
        mdl[IDX_CFG] = 8'hB0;
        mdl[IDX_IRQ_MASK] = 0;
        mdl[IDX_IRQ_STAT] = 0;
        foreach (mdl[i])
            rd(i);
        chk("voltage code", OUTPUT_VOLTAGE_CODE_STRAP, OUTPUT_VOLTAGE_CODE);
        chk("bleed", 1, OUTPUT_BLEED_CTRL);
        apb(0, 8'h20, 0);
        chk("unmapped", 0, q);
        chk("slverr", 1, err);
        $display("test reset values finished");
        repeat (4)
        begin
            d = $urandom;
            apb(1, IDX_HP_SET, d);
            apb(1, IDX_SEQ, d);
            apb(1, IDX_CFG, d & 8'hFE);
            rd(IDX_HP_SET);
            rd(IDX_SEQ);
            rd(IDX_CFG);
            chk("voltage code", d & 8'h3F, OUTPUT_VOLTAGE_CODE);
            chk("soft start rate", d >> 6 & 3, SOFT_START_RATE);
            chk("ramp rate", d >> 2 & 3, VOLTAGE_RAMP_RATE);
            chk("bleed", d >> 5 & 1, OUTPUT_BLEED_CTRL);
        end
        $display("test register access finished");
        apb(1, IDX_HP_SET, 8'h80);
        apb(1, IDX_CFG, 8'hB0);
        for (int i = 0; i < 3; i++)
        begin
            d = (i == 0) ? 0 : (i == 1) ? 7 : $urandom_range(1, 6);
            s = $urandom_range(0, 3);
            abort();
            apb(1, IDX_SEQ, s << 4 | 8 | d);
            step(s ^ 1);
            go_wait(30);
            chk("go absent", 30, n);
            step(s);
            go_wait(40);
            chk("go delay", 1, n >= d * 2 && n <= d * 2 + 5);
            if (n == 40)
                give_verdict();
            tick(1);
            chk("channel on", 1, CH_ON);
        end
        SOFT_START_DONE_FLAG <= 1;
        POWER_GOOD_FLAG <= 1;
        tick(3);
        mdl[IDX_IRQ_STAT] = 2;
        rd(IDX_IRQ_STAT);
        chk("irq out", 0, INTERRUPT_OUT_N);
        apb(1, IDX_IRQ_STAT, 2);
        tick(2);
        chk("irq out", 1, INTERRUPT_OUT_N);
        $display("test sequencing finished");
        apb(1, IDX_HP_SET, 0);
        tick(2);
        chk("channel on", 0, CH_ON);
        apb(1, IDX_HP_SET, 8'h80);
        HP_MODE <= 0;
        onchk(8'hB2, 0);
        OTHER_MODE_EN <= 1;
        onchk(8'hB2, 1);
        onchk(8'hB1, 0);
        OTHER_MODE_EN <= 0;
        onchk(8'hB3, 1);
        onchk(8'hB0, 0);
        $display("test override finished");
        SOFT_START_DONE_FLAG <= 0;
        abort();
        apb(1, IDX_SEQ, 8'h21);
        step(2);
        go_wait(30);
        chk("go absent", 30, n);
        chk("step ready", 1, STEP_READY);
        $display("test no participation finished");
        FAULT_FLAG <= 1;
        tick(3);
        chk("irq out", 1, INTERRUPT_OUT_N);
        FAULT_FLAG <= 0;
        apb(1, IDX_IRQ_STAT, 7);
        apb(1, IDX_CFG, 8'h30);
        FAULT_FLAG <= 1;
        tick(3);
        chk("irq out", 0, INTERRUPT_OUT_N);
        mdl[IDX_IRQ_STAT] = 1;
        rd(IDX_IRQ_STAT);
        apb(1, IDX_IRQ_STAT, 1);
        tick(2);
        chk("irq out", 1, INTERRUPT_OUT_N);
        FAULT_FLAG <= 0;
        apb(1, IDX_IRQ_MASK, 1);
        FAULT_FLAG <= 1;
        tick(3);
        chk("irq out", 1, INTERRUPT_OUT_N);
        rd(IDX_IRQ_MASK);
        $display("test interrupts finished");
        give_verdict();
    end
endmodule // testbench
bind ldocs_channel_ctrl ldocs_sva u_sva (.CLOCK, .NRST, .PSEL, .PENABLE, .PWRITE, .PRDATA,
    .PREADY, .PSLVERR, .STEP_START, .SEQ_ABORT, .FAULT_FLAG, .SOFT_START_DONE_FLAG,
    .POWER_GOOD_FLAG, .SOFT_START_GO, .INTERRUPT_OUT_N);
